// >>> rtl/wdset_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdset_consts.svh"
module wdset_top import wdset_pkg::*; #(
  parameter int SYS_SCALE = 256, // mclk cycles per scaled tick
  parameter int RECOV_STEP = 4096 // rtc ticks per recovery step
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic pwr_up_rst, // clears cause flags only
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic rtc_clk_in, // real-time clock pin
  input wire logic pm_clk_in, // power-management clock pin
  input wire logic [1:0] pwr_mode, // power mode
  output logic fw_rst_req, // firmware reset request
  output logic por_rst_req, // power-on reset request
  output logic irq // interrupt, level
);
  localparam int RECOV_MAX_STEPS = `WDSET_RECOV_MAX_S * `WDSET_RTC_HZ / RECOV_STEP;
  localparam int NDOG = 3;

  // clock-pin synchronisers and edge finders
  logic [2:0] rtc_s_q, rtc_s_d;
  logic [2:0] pm_s_q, pm_s_d;
  logic [15:0] div_q, div_d;
  logic rtc_tick;
  logic pm_tick;
  logic sys_tick;

  assign rtc_tick = rtc_s_q[1] & ~rtc_s_q[2];
  assign pm_tick = pm_s_q[1] & ~pm_s_q[2];
  assign sys_tick = (div_q == 16'(SYS_SCALE - 1));

  // next values of tick logic
  always_comb begin
    rtc_s_d = {rtc_s_q[1:0], rtc_clk_in};
    pm_s_d = {pm_s_q[1:0], pm_clk_in};
    div_d = sys_tick ? 16'h0000 : div_q + 16'h0001;
  end

  // tick registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rtc_s_q <= 3'h0;
      pm_s_q <= 3'h0;
      div_q <= 16'h0000;
    end else begin
      rtc_s_q <= rtc_s_d;
      pm_s_q <= pm_s_d;
      div_q <= div_d;
    end
  end

  // bus handshake: one wait cycle, then commit
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] rd_mux;
  logic bus_req;
  logic commit;
  logic wr;
  logic rd_done;

  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign commit = bus_req & ack_q;
  assign wr = avs_write & commit;
  assign rd_done = avs_read & commit;
  assign avs_readdata = rdata_q;

  // configuration and status storage
  logic [31:0] ctrl_q [NDOG];
  logic [31:0] ctrl_d [NDOG];
  logic [31:0] tmo_q [2];
  logic [31:0] tmo_d [2];
  logic [31:0] win_q [2];
  logic [31:0] win_d [2];
  logic [2:0] cause_q, cause_d;
  logic [4:0] st_q, st_d;
  logic [4:0] mask_q, mask_d;
  logic fw_q, fw_d;
  logic por_q, por_d;
  logic irq_q, irq_d;
  logic [2:0] restart;
  logic [2:0] exp;
  logic [1:0] early;
  logic [2:0] por_sel;
  logic [31:0] dog_cnt [NDOG];
  logic held;
  logic [6:0] steps;
  logic [31:0] recov_tmo;

  assign restart = (wr && avs_address == `WDSET_OFF_RESTART) ? avs_writedata[2:0] : 3'h0;
  assign held = (pwr_mode != PM_ACTIVE);
  assign steps = ctrl_q[2][`WDSET_STEP_LSB +: 7];
  assign recov_tmo = (32'(steps) > 32'(RECOV_MAX_STEPS)) ? 32'(RECOV_MAX_STEPS) : 32'(steps);

  // watchdog instances
  wdset_wd_if wd [NDOG] ();
  genvar gi;
  generate
    for (gi = 0; gi < NDOG; gi++) begin : g_dog
      wdset_wdog u_dog (
        .clk(mclk),
        .rst(sys_rst),
        .wd(wd[gi])
      );
      assign wd[gi].en = ctrl_q[gi][`WDSET_EN_BIT];
      assign wd[gi].restart = restart[gi];
      assign exp[gi] = wd[gi].expire;
      assign dog_cnt[gi] = wd[gi].cnt;
      assign por_sel[gi] = ctrl_q[gi][`WDSET_POR_BIT];
      if (gi < 2) begin : g_prim
        logic [1:0] sel;
        assign sel = ctrl_q[gi][`WDSET_SEL_LSB +: 2];
        assign wd[gi].win_en = ctrl_q[gi][`WDSET_WIN_BIT];
        assign wd[gi].tick = (sel == SRC_SYS) ? sys_tick :
          (sel == SRC_RTC) ? rtc_tick : (sel == SRC_PM) ? pm_tick : 1'b0;
        assign wd[gi].hold = held;
        assign wd[gi].presc = ctrl_q[gi][`WDSET_PRE_LSB +: 16];
        assign wd[gi].tmo = tmo_q[gi];
        assign wd[gi].win = win_q[gi];
        assign early[gi] = wd[gi].early;
      end else begin : g_recov
        assign wd[gi].win_en = 1'b0;
        assign wd[gi].win = 32'h0000_0000;
        assign wd[gi].hold = 1'b0;
        assign wd[gi].tick = rtc_tick;
        assign wd[gi].presc = 16'(RECOV_STEP - 1);
        assign wd[gi].tmo = recov_tmo;
      end
    end
  endgenerate

  // read data select, unmapped reads as zero
  always_comb begin
    case (avs_address)
      `WDSET_OFF_CTRL_A: rd_mux = ctrl_q[0];
      `WDSET_OFF_TMO_A: rd_mux = tmo_q[0];
      `WDSET_OFF_WIN_A: rd_mux = win_q[0];
      `WDSET_OFF_CTRL_B: rd_mux = ctrl_q[1];
      `WDSET_OFF_TMO_B: rd_mux = tmo_q[1];
      `WDSET_OFF_WIN_B: rd_mux = win_q[1];
      `WDSET_OFF_CTRL_R: rd_mux = ctrl_q[2];
      `WDSET_OFF_CAUSE: rd_mux = {29'h0, cause_q};
      `WDSET_OFF_STATUS: rd_mux = {27'h0, st_q};
      `WDSET_OFF_MASK: rd_mux = {27'h0, mask_q};
      `WDSET_OFF_CNT_A: rd_mux = dog_cnt[0];
      `WDSET_OFF_CNT_B: rd_mux = dog_cnt[1];
      `WDSET_OFF_CNT_R: rd_mux = dog_cnt[2];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next values of bus and register state
  always_comb begin
    ack_d = bus_req & ~ack_q;
    rdata_d = (avs_read & ~ack_q) ? rd_mux : rdata_q;
    ctrl_d = ctrl_q;
    tmo_d = tmo_q;
    win_d = win_q;
    mask_d = mask_q;
    if (wr) begin
      case (avs_address)
        `WDSET_OFF_CTRL_A: ctrl_d[0] = avs_writedata & `WDSET_CTRL_P_MASK;
        `WDSET_OFF_TMO_A: tmo_d[0] = avs_writedata;
        `WDSET_OFF_WIN_A: win_d[0] = avs_writedata;
        `WDSET_OFF_CTRL_B: ctrl_d[1] = avs_writedata & `WDSET_CTRL_P_MASK;
        `WDSET_OFF_TMO_B: tmo_d[1] = avs_writedata;
        `WDSET_OFF_WIN_B: win_d[1] = avs_writedata;
        `WDSET_OFF_CTRL_R: ctrl_d[2] = avs_writedata & `WDSET_CTRL_R_MASK;
        `WDSET_OFF_MASK: mask_d = avs_writedata[4:0];
        default: mask_d = mask_q;
      endcase
    end
  end

  // next values of events, flags and reset requests
  always_comb begin
    cause_d = cause_q;
    if (wr && avs_address == `WDSET_OFF_CAUSE) begin
      cause_d = cause_q & ~avs_writedata[2:0];
    end
    cause_d = cause_d | exp;
    // sticky status: a read clears only the bits it reported, so an event
    // landing between capture and commit is kept; new event wins
    st_d = (rd_done && avs_address == `WDSET_OFF_STATUS) ? (st_q & ~rdata_q[4:0]) : st_q;
    st_d = st_d | {early, exp};
    fw_d = fw_q | (|(exp & ~por_sel));
    por_d = por_q | (|(exp & por_sel));
    irq_d = |(st_q & mask_q);
  end

  // bus and configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      for (int i = 0; i < NDOG; i++) begin
        ctrl_q[i] <= `WDSET_CTRL_RST;
      end
      for (int i = 0; i < 2; i++) begin
        tmo_q[i] <= `WDSET_TMO_RST;
        win_q[i] <= `WDSET_WIN_RST;
      end
      mask_q <= `WDSET_MASK_RST;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      tmo_q <= tmo_d;
      win_q <= win_d;
      mask_q <= mask_d;
    end
  end

  // event registers, cleared by system reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= 5'h00;
      fw_q <= 1'b0;
      por_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fw_q <= fw_d;
      por_q <= por_d;
      irq_q <= irq_d;
    end
  end

  // cause flags survive the reset they explain
  always_ff @(posedge mclk) begin
    if (pwr_up_rst) begin
      cause_q <= 3'h0;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign fw_rst_req = fw_q;
  assign por_rst_req = por_q;
  assign irq = irq_q;

  // checks
  property p_fw_req;
    @(posedge mclk) disable iff (sys_rst)
      exp[0] && !por_sel[0] |=> fw_rst_req ##1 fw_rst_req;
  endproperty
  a_fw_req: assert property (p_fw_req) else $error("firmware reset not requested");
  property p_cause_a;
    @(posedge mclk) disable iff (sys_rst || pwr_up_rst)
      exp[0] |=> cause_q[0];
  endproperty
  a_cause_a: assert property (p_cause_a) else $error("cause flag A not set");
  property p_cause_r;
    @(posedge mclk) disable iff (sys_rst || pwr_up_rst)
      exp[2] |=> cause_q[2] ##1 (cause_q[2] || $past(wr));
  endproperty
  a_cause_r: assert property (p_cause_r) else $error("recovery cause not set");
  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
      pwr_mode == PM_DEEP |-> wd[0].hold && wd[1].hold && !wd[2].hold;
  endproperty
  a_hold: assert property (p_hold) else $error("deep mode hold wrong");
endmodule : wdset_top
`default_nettype wire

// >>> rtl/wdset_consts.svh
`ifndef WDSET_CONSTS_SVH
`define WDSET_CONSTS_SVH
// register byte offsets
`define WDSET_OFF_CTRL_A 6'h00
`define WDSET_OFF_TMO_A 6'h04
`define WDSET_OFF_WIN_A 6'h08
`define WDSET_OFF_CTRL_B 6'h0C
`define WDSET_OFF_TMO_B 6'h10
`define WDSET_OFF_WIN_B 6'h14
`define WDSET_OFF_CTRL_R 6'h18
`define WDSET_OFF_RESTART 6'h1C
`define WDSET_OFF_CAUSE 6'h20
`define WDSET_OFF_STATUS 6'h24
`define WDSET_OFF_MASK 6'h28
`define WDSET_OFF_CNT_A 6'h2C
`define WDSET_OFF_CNT_B 6'h30
`define WDSET_OFF_CNT_R 6'h34
// control field positions
`define WDSET_EN_BIT 0
`define WDSET_WIN_BIT 1
`define WDSET_POR_BIT 2
`define WDSET_SEL_LSB 3
`define WDSET_PRE_LSB 8
`define WDSET_STEP_LSB 8
// writable bits and reset values
`define WDSET_CTRL_P_MASK 32'h00FF_FF1F
`define WDSET_CTRL_R_MASK 32'h0000_7F05
`define WDSET_CTRL_RST 32'h0000_0000
`define WDSET_TMO_RST 32'hFFFF_FFFF
`define WDSET_WIN_RST 32'h0000_0000
`define WDSET_MASK_RST 5'h00
// timing figures
`define WDSET_RECOV_MAX_S 8
`define WDSET_RTC_HZ 32768
`endif

// >>> rtl/wdset_pkg.sv
package wdset_pkg;
  // per watchdog state
  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_RUN = 2'b01,
    WD_EXP = 2'b10
  } wdset_st_t;
  // system power mode
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_RETAIN = 2'b01,
    PM_DEEP = 2'b10
  } wdset_pmode_t;
  // count clock source
  typedef enum logic [1:0] {
    SRC_SYS = 2'b00,
    SRC_RTC = 2'b01,
    SRC_PM = 2'b10
  } wdset_src_t;
endpackage : wdset_pkg

// >>> rtl/wdset_wd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface wdset_wd_if;
  logic en;
  logic win_en;
  logic restart;
  logic tick;
  logic hold;
  logic [15:0] presc;
  logic [31:0] tmo;
  logic [31:0] win;
  logic expire;
  logic early;
  logic [31:0] cnt;
  modport ctl (output en, win_en, restart, tick, hold, presc, tmo, win,
    input expire, early, cnt);
  modport dog (input en, win_en, restart, tick, hold, presc, tmo, win,
    output expire, early, cnt);
endinterface : wdset_wd_if
`default_nettype wire

// >>> rtl/wdset_wdog.sv
`timescale 1ns/100ps
`default_nettype none
module wdset_wdog import wdset_pkg::*; (
  input wire logic clk, // module clock
  input wire logic rst, // sync reset, active high
  wdset_wd_if.dog wd // control and status
);
  wdset_st_t st_q, st_d;
  logic [15:0] pre_q, pre_d;
  logic [31:0] cnt_q, cnt_d;
  logic exp_q, exp_d;
  logic early_q, early_d;
  logic too_early;
  logic [31:0] cnt_inc;

  assign too_early = wd.win_en && (cnt_q < wd.win);
  assign cnt_inc = cnt_q + 32'h0000_0001;

  // next state of prescaler, counter and expiry
  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    early_d = 1'b0;
    if (!wd.en) begin
      st_d = WD_OFF;
      pre_d = 16'h0000;
      cnt_d = 32'h0000_0000;
    end else begin
      case (st_q)
        WD_OFF: begin
          st_d = WD_RUN;
        end
        WD_RUN: begin
          if (wd.restart) begin
            if (too_early) begin
              exp_d = 1'b1;
              early_d = 1'b1;
              st_d = WD_EXP;
            end else begin
              pre_d = 16'h0000;
              cnt_d = 32'h0000_0000;
            end
          end else if (wd.tick && !wd.hold) begin
            if (pre_q == wd.presc) begin
              pre_d = 16'h0000;
              cnt_d = cnt_inc;
              if (cnt_inc >= wd.tmo) begin
                exp_d = 1'b1;
                st_d = WD_EXP;
              end
            end else begin
              pre_d = pre_q + 16'h0001;
            end
          end
        end
        WD_EXP: begin
          st_d = WD_EXP; // waits for disable or reset
        end
        default: begin
          st_d = WD_OFF;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= WD_OFF;
      pre_q <= 16'h0000;
      cnt_q <= 32'h0000_0000;
      exp_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
      early_q <= early_d;
    end
  end

  assign wd.expire = exp_q;
  assign wd.early = early_q;
  assign wd.cnt = cnt_q;

  // checks
  property p_off_quiet;
    @(posedge clk) disable iff (rst) !wd.en |=> !exp_q && cnt_q == 32'h0000_0000;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled dog moved");
  property p_early;
    @(posedge clk) disable iff (rst)
      wd.en && st_q == WD_RUN && wd.restart && too_early |=> exp_q && early_q ##1 !exp_q;
  endproperty
  a_early: assert property (p_early) else $error("early restart not caught");
  property p_restart;
    @(posedge clk) disable iff (rst)
      wd.en && st_q == WD_RUN && wd.restart && !too_early |=> cnt_q == 32'h0 && !exp_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");
  property p_hold;
    @(posedge clk) disable iff (rst)
      wd.en && wd.hold && !wd.restart && st_q == WD_RUN |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("held dog counted");
  property p_tmo;
    @(posedge clk) disable iff (rst)
      wd.en && st_q == WD_RUN && !wd.restart && wd.tick && !wd.hold
      && pre_q == wd.presc && cnt_inc >= wd.tmo |=> exp_q ##1 st_q == WD_EXP;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missed");
endmodule : wdset_wdog
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdset_consts.svh"
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwr_up_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rtc_clk_in = 1'b0;
  logic pm_clk_in = 1'b0;
  logic [1:0] pwr_mode = 2'h0;
  logic fw_rst_req;
  logic por_rst_req;
  logic irq;
  logic [3:0] div_q = 4'h0;
  int fails = 0;
  int checks = 0;
  int n;
  int s;

  // short counts keep the run brief
  wdset_top #(.SYS_SCALE(4), .RECOV_STEP(4)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .pwr_up_rst(pwr_up_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rtc_clk_in(rtc_clk_in),
    .pm_clk_in(pm_clk_in), .pwr_mode(pwr_mode), .fw_rst_req(fw_rst_req),
    .por_rst_req(por_rst_req), .irq(irq)
  );

  // system clock, 4 ns period
  always #2 mclk = ~mclk;

  // slow clock pins derived on the rising edge, well under mclk/2
  always @(posedge mclk) begin
    div_q <= div_q + 4'h1;
    rtc_clk_in <= div_q[2];
    pm_clk_in <= div_q[3];
  end

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      k++;
      if (k > 50) begin
        fails++;
        tally_and_finish();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rdc

  // bounded wait for a reset request, cycles counted in cnt
  task automatic wait_req(input logic por, output int cnt);
    cnt = 0;
    while ((por ? por_rst_req : fw_rst_req) !== 1'b1) begin
      if (cnt == 3000) begin
        fails++;
        tally_and_finish();
      end
      @(posedge mclk);
      cnt++;
    end
  endtask : wait_req

  task automatic do_reset(input logic pu);
    @(posedge mclk);
    sys_rst <= 1'b1;
    pwr_up_rst <= pu;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    pwr_up_rst <= 1'b0;
  endtask : do_reset

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    pwr_up_rst <= 1'b0;
    // reset values, masks and unmapped places
    rdc(`WDSET_OFF_CTRL_A, `WDSET_CTRL_RST);
    rdc(`WDSET_OFF_TMO_B, `WDSET_TMO_RST);
    rdc(`WDSET_OFF_WIN_A, `WDSET_WIN_RST);
    rdc(`WDSET_OFF_MASK, 32'h0000_0000);
    rdc(`WDSET_OFF_CAUSE, 32'h0000_0000);
    wr(`WDSET_OFF_CTRL_R, 32'hFFFF_FFFF);
    rdc(`WDSET_OFF_CTRL_R, `WDSET_CTRL_R_MASK);
    wr(`WDSET_OFF_CTRL_B, 32'hFFFF_FFFE);
    rdc(`WDSET_OFF_CTRL_B, 32'h00FF_FF1E);
    wr(6'h3C, 32'h1234_5678);
    rdc(6'h3C, 32'h0000_0000);
    rdc(`WDSET_OFF_RESTART, 32'h0000_0000);
    do_reset(1'b1);
    wr(`WDSET_OFF_TMO_A, 32'h0000_0001);
    wr(`WDSET_OFF_CTRL_A, 32'h0000_0006);
    // dog B enabled with no count source never moves
    wr(`WDSET_OFF_TMO_B, 32'h0000_0001);
    wr(`WDSET_OFF_CTRL_B, 32'h0000_0019);
    repeat (100) @(posedge mclk);
    chk(fw_rst_req | por_rst_req, 1'b0);
    rdc(`WDSET_OFF_CNT_A, 32'h0000_0000);
    rdc(`WDSET_OFF_CNT_B, 32'h0000_0000);
    // each count source expires the dog; mask off for the rtc pass
    for (s = 0; s < 3; s++) begin
      do_reset(1'b0);
      wr(`WDSET_OFF_MASK, (s == 1) ? 32'h0 : 32'h1F);
      wr(`WDSET_OFF_TMO_A, 32'h0000_0003);
      wr(`WDSET_OFF_CTRL_A, 32'h0000_0001 | (s << `WDSET_SEL_LSB));
      wait_req(1'b0, n);
      chk(por_rst_req, 1'b0);
      repeat (2) @(posedge mclk);
      chk(irq, (s != 1));
      rdc(`WDSET_OFF_STATUS, 32'h0000_0001);
      rdc(`WDSET_OFF_CAUSE, 32'h0000_0001);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
    end
    // cause survives system reset, then clears by write
    do_reset(1'b0);
    rdc(`WDSET_OFF_CAUSE, 32'h0000_0001);
    wr(`WDSET_OFF_CAUSE, 32'h0000_0007);
    rdc(`WDSET_OFF_CAUSE, 32'h0000_0000);
    // restarts hold off expiry, then prescaled timeout
    wr(`WDSET_OFF_TMO_B, 32'h0000_0002);
    wr(`WDSET_OFF_CTRL_B, 32'h0000_0301);
    for (s = 0; s < 8; s++) begin
      repeat (6) @(posedge mclk);
      wr(`WDSET_OFF_RESTART, 32'h0000_0002);
    end
    chk(fw_rst_req, 1'b0);
    wait_req(1'b0, n);
    // 2 counts x 4 ticks x 4 mclk plus latency
    chk((n >= 28 && n <= 44), 1'b1);
    rdc(`WDSET_OFF_CAUSE, 32'h0000_0002);
    // early restart in window mode gives power-on request
    do_reset(1'b1);
    wr(`WDSET_OFF_WIN_B, 32'h0000_0064);
    wr(`WDSET_OFF_TMO_B, 32'h0000_00C8);
    wr(`WDSET_OFF_CTRL_B, 32'h0000_0007);
    wr(`WDSET_OFF_RESTART, 32'h0000_0002);
    wait_req(1'b1, n);
    chk((n <= 4), 1'b1);
    chk(fw_rst_req, 1'b0);
    rdc(`WDSET_OFF_STATUS, 32'h0000_0012);
    // restart inside the window is accepted
    do_reset(1'b1);
    wr(`WDSET_OFF_WIN_B, 32'h0000_0002);
    wr(`WDSET_OFF_TMO_B, 32'h0000_0008);
    wr(`WDSET_OFF_CTRL_B, 32'h0000_0007);
    repeat (20) @(posedge mclk);
    wr(`WDSET_OFF_RESTART, 32'h0000_0002);
    repeat (5) @(posedge mclk);
    chk(por_rst_req, 1'b0);
    wait_req(1'b1, n);
    rdc(`WDSET_OFF_STATUS, 32'h0000_0002);
    // recovery keeps counting in both sleep modes, primaries freeze
    for (s = 1; s < 3; s++) begin
      do_reset(1'b1);
      pwr_mode <= s[1:0];
      wr(`WDSET_OFF_TMO_A, 32'h0000_0001);
      wr(`WDSET_OFF_CTRL_A, 32'h0000_0001);
      // s steps of 4 rtc ticks, 8 mclk per tick, plus latency
      wr(`WDSET_OFF_CTRL_R, 32'h0000_0001 | (s << `WDSET_STEP_LSB));
      wait_req(1'b0, n);
      chk((n >= 32 * s - 8 && n <= 32 * s + 8), 1'b1);
      rdc(`WDSET_OFF_STATUS, 32'h0000_0004);
      rdc(`WDSET_OFF_CNT_A, 32'h0000_0000);
      rdc(`WDSET_OFF_CAUSE, 32'h0000_0004);
      pwr_mode <= 2'h0;
    end
    // restarts hold off the recovery dog, then it times out
    do_reset(1'b1);
    wr(`WDSET_OFF_CTRL_R, 32'h0000_0105);
    for (s = 0; s < 4; s++) begin
      repeat (10) @(posedge mclk);
      wr(`WDSET_OFF_RESTART, 32'h0000_0004);
    end
    chk(por_rst_req, 1'b0);
    wait_req(1'b1, n);
    chk((n >= 24 && n <= 40), 1'b1);
    chk(fw_rst_req, 1'b0);
    rdc(`WDSET_OFF_CAUSE, 32'h0000_0004);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
